// [inc/tla_pkg.sv]
// Constants and types for the temperature limit alert block
package tla_pkg;
  localparam int REM_W = 11;
  localparam int LOC_W = 8;
  localparam int HYST_W = 8;
  localparam int STATUS_W = 8;
  localparam int REM_FRAC_SH = 3;
  localparam int FQ_DEPTH = 3;
  localparam int CLK_FREQ_MHZ = 40;
  localparam int CONV_GAP_US = 1000;
  localparam int CONV_GAP_CYC = CONV_GAP_US * CLK_FREQ_MHZ;
  localparam int MODE_BIT = 0;
  localparam logic MODE_INT = 1'b0;
  localparam logic MODE_CMP = 1'b1;
  localparam logic SUPPRESS_RST = 1'b0;
  // Condition indices
  localparam int NCOND = 5;
  localparam int C_RHI = 0;
  localparam int C_RLO = 1;
  localparam int C_LHI = 2;
  localparam int C_RCRIT = 3;
  localparam int C_LCRIT = 4;
  localparam logic [NCOND-1:0] LIM_MASK = 5'h07;
  localparam logic [NCOND-1:0] REM_MASK = 5'h0b;
  // Status bit positions
  localparam int ST_BUSY = 7;
  localparam int ST_LHI = 6;
  localparam int ST_RHI = 4;
  localparam int ST_RLO = 3;
  localparam int ST_OPEN = 2;
  localparam int ST_RCRIT = 1;
  localparam int ST_LCRIT = 0;
  typedef enum logic [3:0] {
    SEQ_IDLE = 4'h1,
    SEQ_REM = 4'h2,
    SEQ_LOC = 4'h4,
    SEQ_GAP = 4'h8
  } tla_seq_t;
endpackage : tla_pkg

// [rtl/tla_alert_core.sv]
// Limit checking, status flags, alert and critical outputs, conversion sequencer
`timescale 1ns/1ps
`default_nettype none
module tla_alert_core #(
  parameter int CONV_GAP = tla_pkg::CONV_GAP_CYC,
  parameter int FQ_DEPTH = tla_pkg::FQ_DEPTH
) (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic SHUTDOWN,
  input wire logic [7:0] ALERT_MODE_REG,
  input wire logic FAULT_QUEUE_EN,
  input wire logic [tla_pkg::NCOND-1:0] COND_EN,
  input wire logic ONE_SHOT,
  input wire logic STATUS_RD,
  input wire logic SUPPRESS_WR,
  input wire logic SUPPRESS_WDATA,
  input wire logic [tla_pkg::REM_W-1:0] REMOTE_HIGH_LIMIT,
  input wire logic [tla_pkg::REM_W-1:0] REMOTE_LOW_LIMIT,
  input wire logic [tla_pkg::LOC_W-1:0] LOCAL_HIGH_LIMIT,
  input wire logic [tla_pkg::REM_W-1:0] REMOTE_CRITICAL_LIMIT,
  input wire logic [tla_pkg::LOC_W-1:0] LOCAL_CRITICAL_LIMIT,
  input wire logic [tla_pkg::HYST_W-1:0] CRIT_HYST,
  input wire logic ADC_DONE,
  input wire logic [tla_pkg::REM_W-1:0] ADC_RESULT,
  input wire logic DIODE_OPEN,
  output logic ADC_START,
  output logic ADC_REMOTE,
  output logic ADC_ABORT,
  output logic [tla_pkg::REM_W-1:0] REMOTE_TEMP,
  output logic [tla_pkg::LOC_W-1:0] LOCAL_TEMP,
  output logic [tla_pkg::STATUS_W-1:0] STATUS,
  output logic ALERT_SUPPRESS_BIT,
  output logic ALERT_N,
  output logic CRIT_N
);
  localparam int GW = $clog2(CONV_GAP + 1);
  localparam logic [GW-1:0] GAP_LAST = GW'(CONV_GAP - 1);
  localparam int RX = tla_pkg::REM_W + 2;
  localparam int LX = tla_pkg::LOC_W + 2;

  logic [1:0] rst_sync;
  logic rst_n;
  tla_pkg::tla_seq_t state;
  tla_pkg::tla_seq_t next_state;
  logic [GW-1:0] gap_cnt;
  logic shut_q;
  logic shut_rise;
  logic rem_done;
  logic loc_done;
  logic cmp_mode;
  logic rd_int;
  logic [tla_pkg::NCOND-1:0] raw;
  logic [tla_pkg::NCOND-1:0] hit;
  logic [tla_pkg::NCOND-1:0] upd;
  logic [tla_pkg::NCOND-1:0] qen;
  logic [tla_pkg::NCOND-1:0] lvl;
  logic [tla_pkg::NCOND-1:0] fset;
  logic [tla_pkg::NCOND-1:0] fclr;
  logic [tla_pkg::NCOND-1:0] flag;
  logic [tla_pkg::NCOND-1:0] next_flag;
  logic [1:0] crit_act;
  logic [1:0] next_crit_act;
  logic rem_rel;
  logic loc_rel;
  logic alert;
  logic next_alert;
  logic trig;
  logic open_q;
  logic signed [RX-1:0] rres_x;
  logic signed [RX-1:0] rcrit_x;
  logic signed [LX-1:0] lres_x;
  logic signed [LX-1:0] lcrit_x;

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  assign cmp_mode = (ALERT_MODE_REG[tla_pkg::MODE_BIT] == tla_pkg::MODE_CMP);
  assign rd_int = STATUS_RD & !cmp_mode;
  assign shut_rise = SHUTDOWN & !shut_q;

  // Conversion sequencer
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      shut_q <= 1'b0;
    end else begin
      shut_q <= SHUTDOWN;
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      tla_pkg::SEQ_IDLE: begin
        if (!SHUTDOWN || ONE_SHOT) begin
          next_state = tla_pkg::SEQ_REM;
        end
      end
      tla_pkg::SEQ_REM: begin
        if (shut_rise) begin
          next_state = tla_pkg::SEQ_IDLE;
        end else if (ADC_DONE) begin
          next_state = tla_pkg::SEQ_LOC;
        end
      end
      tla_pkg::SEQ_LOC: begin
        if (shut_rise) begin
          next_state = tla_pkg::SEQ_IDLE;
        end else if (ADC_DONE) begin
          next_state = SHUTDOWN ? tla_pkg::SEQ_IDLE : tla_pkg::SEQ_GAP;
        end
      end
      tla_pkg::SEQ_GAP: begin
        if (SHUTDOWN) begin
          next_state = tla_pkg::SEQ_IDLE;
        end else if (gap_cnt == GAP_LAST) begin
          next_state = tla_pkg::SEQ_REM;
        end
      end
      default: begin
        next_state = tla_pkg::SEQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      state <= tla_pkg::SEQ_IDLE;
      gap_cnt <= '0;
    end else begin
      state <= next_state;
      if (state != tla_pkg::SEQ_GAP) begin
        gap_cnt <= '0;
      end else begin
        gap_cnt <= gap_cnt + 1'b1;
      end
    end
  end

  // Front end handshake
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      ADC_START <= 1'b0;
      ADC_REMOTE <= 1'b0;
      ADC_ABORT <= 1'b0;
    end else begin
      ADC_START <= (next_state != state) &&
                   (next_state == tla_pkg::SEQ_REM || next_state == tla_pkg::SEQ_LOC);
      ADC_REMOTE <= (next_state == tla_pkg::SEQ_REM);
      ADC_ABORT <= shut_rise && (state == tla_pkg::SEQ_REM || state == tla_pkg::SEQ_LOC);
    end
  end

  // A done in the abort cycle is dropped: partial results never land
  assign rem_done = ADC_DONE & (state == tla_pkg::SEQ_REM) & !shut_rise;
  assign loc_done = ADC_DONE & (state == tla_pkg::SEQ_LOC) & !shut_rise;

  // Result registers load as each conversion ends
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      REMOTE_TEMP <= '0;
      LOCAL_TEMP <= '0;
    end else begin
      if (rem_done) begin
        REMOTE_TEMP <= ADC_RESULT;
      end
      if (loc_done) begin
        LOCAL_TEMP <= ADC_RESULT[tla_pkg::LOC_W-1:0];
      end
    end
  end

  // Signed limit compares; local result sits in the low byte
  always_comb begin
    raw = '0;
    raw[tla_pkg::C_RHI] = $signed(ADC_RESULT) > $signed(REMOTE_HIGH_LIMIT);
    raw[tla_pkg::C_RLO] = $signed(ADC_RESULT) < $signed(REMOTE_LOW_LIMIT);
    raw[tla_pkg::C_RCRIT] = $signed(ADC_RESULT) > $signed(REMOTE_CRITICAL_LIMIT);
    raw[tla_pkg::C_LHI] = $signed(ADC_RESULT[tla_pkg::LOC_W-1:0]) >
                          $signed(LOCAL_HIGH_LIMIT);
    raw[tla_pkg::C_LCRIT] = $signed(ADC_RESULT[tla_pkg::LOC_W-1:0]) >
                            $signed(LOCAL_CRITICAL_LIMIT);
  end

  // Hysteresis is in whole degrees; remote scales it to eighths
  assign rres_x = $signed({{2{ADC_RESULT[tla_pkg::REM_W-1]}}, ADC_RESULT});
  assign rcrit_x = $signed({{2{REMOTE_CRITICAL_LIMIT[tla_pkg::REM_W-1]}}, REMOTE_CRITICAL_LIMIT}) -
                   $signed({2'b00, CRIT_HYST, 3'b000});
  assign lres_x = $signed({{2{ADC_RESULT[tla_pkg::LOC_W-1]}}, ADC_RESULT[tla_pkg::LOC_W-1:0]});
  assign lcrit_x = $signed({{2{LOCAL_CRITICAL_LIMIT[tla_pkg::LOC_W-1]}}, LOCAL_CRITICAL_LIMIT}) -
                   $signed({2'b00, CRIT_HYST});
  assign rem_rel = rres_x < rcrit_x;
  assign loc_rel = lres_x < lcrit_x;

  always_comb begin
    upd = {loc_done, rem_done, loc_done, rem_done, rem_done};
    qen = tla_pkg::REM_MASK & {tla_pkg::NCOND{FAULT_QUEUE_EN}};
  end

  genvar gi;
  generate
    for (gi = 0; gi < tla_pkg::NCOND; gi++) begin : g_qual
      tla_fault_qual #(
        .DEPTH(FQ_DEPTH)
      ) u_qual (
        .clk(CLK),
        .rst_n(rst_n),
        .upd(upd[gi]),
        .raw(raw[gi]),
        .queue_en(qen[gi]),
        .hit(hit[gi])
      );
    end
  endgenerate

  // Critical state per channel: index 0 remote, 1 local
  always_comb begin
    next_crit_act = crit_act;
    if (rem_done) begin
      if (hit[tla_pkg::C_RCRIT]) begin
        next_crit_act[0] = 1'b1;
      end else if (rem_rel) begin
        next_crit_act[0] = 1'b0;
      end
    end
    if (loc_done) begin
      if (hit[tla_pkg::C_LCRIT]) begin
        next_crit_act[1] = 1'b1;
      end else if (loc_rel) begin
        next_crit_act[1] = 1'b0;
      end
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      crit_act <= 2'b00;
    end else begin
      crit_act <= next_crit_act;
    end
  end

  // Flag update: hardware set wins over a clear in the same cycle
  always_comb begin
    lvl = hit;
    lvl[tla_pkg::C_RCRIT] = next_crit_act[0];
    lvl[tla_pkg::C_LCRIT] = next_crit_act[1];
    fset = upd & lvl;
    if (cmp_mode) begin
      fclr = upd & ~lvl;
    end else begin
      fclr = {tla_pkg::NCOND{rd_int}};
    end
    next_flag = (flag & ~fclr) | fset;
  end

  // Shutdown never clears flags and never moves ALERT_N or CRIT_N
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      flag <= '0;
      open_q <= 1'b0;
    end else begin
      flag <= next_flag;
      open_q <= DIODE_OPEN;
    end
  end

  // Suppress bit: interrupt-mode status read with a flag set sets it, host write of 0 clears it
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      ALERT_SUPPRESS_BIT <= tla_pkg::SUPPRESS_RST;
    end else if (rd_int && (flag != '0)) begin
      ALERT_SUPPRESS_BIT <= 1'b1;
    end else if (SUPPRESS_WR) begin
      ALERT_SUPPRESS_BIT <= SUPPRESS_WDATA;
    end
  end

  // Alert pin; only limit conditions, crit has its own pin
  assign trig = |(fset & COND_EN & tla_pkg::LIM_MASK);

  always_comb begin
    if (cmp_mode) begin
      // New assertion only at a conversion end; suppress never releases
      next_alert = (|(next_flag & COND_EN & tla_pkg::LIM_MASK)) &
                   (alert | (trig & !ALERT_SUPPRESS_BIT));
    end else if (trig && !ALERT_SUPPRESS_BIT) begin
      next_alert = 1'b1;
    end else if (rd_int) begin
      next_alert = 1'b0;
    end else begin
      next_alert = alert;
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      alert <= 1'b0;
      ALERT_N <= 1'b1;
      CRIT_N <= 1'b1;
    end else begin
      alert <= next_alert;
      ALERT_N <= !next_alert;
      // Suppress deliberately absent here
      CRIT_N <= !(|(next_crit_act & {COND_EN[tla_pkg::C_LCRIT],
                                     COND_EN[tla_pkg::C_RCRIT]}));
    end
  end

  // Status image; lags internal flags by one cycle
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      STATUS <= '0;
    end else begin
      STATUS <= '0;
      STATUS[tla_pkg::ST_BUSY] <= (state == tla_pkg::SEQ_REM) ||
                                  (state == tla_pkg::SEQ_LOC);
      STATUS[tla_pkg::ST_LHI] <= flag[tla_pkg::C_LHI];
      STATUS[tla_pkg::ST_RHI] <= flag[tla_pkg::C_RHI];
      STATUS[tla_pkg::ST_RLO] <= flag[tla_pkg::C_RLO];
      STATUS[tla_pkg::ST_OPEN] <= open_q;
      STATUS[tla_pkg::ST_RCRIT] <= flag[tla_pkg::C_RCRIT];
      STATUS[tla_pkg::ST_LCRIT] <= flag[tla_pkg::C_LCRIT];
    end
  end
endmodule : tla_alert_core
`default_nettype wire

// [rtl/tla_fault_qual.sv]
// Consecutive out-of-limit qualifier for one condition
`timescale 1ns/1ps
`default_nettype none
module tla_fault_qual #(
  parameter int DEPTH = 3
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic upd,
  input wire logic raw,
  input wire logic queue_en,
  output logic hit
);
  localparam int CW = (DEPTH > 2) ? $clog2(DEPTH) : 1;
  localparam logic [CW-1:0] CNT_MAX = CW'(DEPTH - 1);
  logic [CW-1:0] cnt;

  // Counts prior consecutive violations; saturates at DEPTH-1
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= '0;
    end else if (upd) begin
      if (!raw) begin
        cnt <= '0;
      end else if (cnt != CNT_MAX) begin
        cnt <= cnt + 1'b1;
      end
    end
  end

  // Third violation in a row qualifies when queue is on
  assign hit = raw & (!queue_en | (cnt == CNT_MAX));
endmodule : tla_fault_qual
`default_nettype wire

// [tb/tb.sv]
// Self-checking bench for the limit alert core
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk = 0, arst_n = 0, sd = 1, os = 0, rd = 0, sw = 0, swd = 0, fq = 0, slow = 0;
  logic dop = 0, done, go, ab, rem, sup, al_n, cr_n;
  logic [7:0] mode = 8'h00, lh = 8'h19, lc = 8'h32, hy = 8'h05, lv = 8'h00, lt, st;
  logic [4:0] en = 5'h1f;
  logic [10:0] rh = 11'h0c8, rl = 11'h008, rc = 11'h190, rv = 11'h000, res, rt, r;
  int miscompares = 0, compares = 0, cyc = 0, nab = 0, nst = 0;
  tla_alert_core #(.CONV_GAP(8), .FQ_DEPTH(3)) i_dut (.CLK(clk), .ARST_N(arst_n),
    .SHUTDOWN(sd), .ALERT_MODE_REG(mode), .FAULT_QUEUE_EN(fq), .COND_EN(en), .ONE_SHOT(os),
    .STATUS_RD(rd), .SUPPRESS_WR(sw), .SUPPRESS_WDATA(swd), .REMOTE_HIGH_LIMIT(rh),
    .REMOTE_LOW_LIMIT(rl), .LOCAL_HIGH_LIMIT(lh), .REMOTE_CRITICAL_LIMIT(rc),
    .LOCAL_CRITICAL_LIMIT(lc), .CRIT_HYST(hy), .ADC_DONE(done), .ADC_RESULT(res),
    .DIODE_OPEN(dop), .ADC_START(go), .ADC_REMOTE(rem), .ADC_ABORT(ab), .REMOTE_TEMP(rt),
    .LOCAL_TEMP(lt), .STATUS(st), .ALERT_SUPPRESS_BIT(sup), .ALERT_N(al_n), .CRIT_N(cr_n));
  tla_fe_model i_fe (.clk(clk), .start(go), .remote(rem), .abort(ab), .slow(slow),
    .rem_val(rv), .loc_val(lv), .done(done), .result(res));
  initial begin
    forever #12.5 clk = ~clk;
  end
  function automatic logic hi(logic [10:0] v, logic [10:0] lim);
    return $signed(v) > $signed(lim);
  endfunction : hi
  task automatic stop_test();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : stop_test
  // Ceiling well above the roughly 600 cycles the tests need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      stop_test();
    end
  end
  task automatic chk(string n, logic [10:0] e, logic [10:0] g);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic pins(logic a, logic c, logic [7:0] s);
    chk("pins", {1'b0, a, c, s}, {1'b0, al_n, cr_n, st});
  endtask : pins
  task automatic run(int n);
    repeat (n) begin
      @(negedge clk);
      if (ab) nab++;
      if (go && rem) nst++;
    end
  endtask : run
  task automatic pair(logic [10:0] rr, logic [7:0] l);
    int n = 0;
    rv = rr;
    lv = l;
    os = 1'b1;
    @(negedge clk);
    os = 1'b0;
    while (n < 2 && cyc < 20000) begin
      @(negedge clk);
      if (done) n++;
    end
    run(3);
  endtask : pair
  task automatic strobe(logic rdq, logic swq, logic v);
    rd = rdq;
    sw = swq;
    swd = v;
    @(negedge clk);
    rd = 1'b0;
    sw = 1'b0;
    run(2);
  endtask : strobe
  initial begin
    void'($urandom(32'h32f69765));
    run(20);
    arst_n = 1'b1;
    run(4);
    pair(rh, lh);
    pins(1, 1, 8'h00);
    pair(rh + 11'h001, 8'h05);
    pins(0, 1, 8'h10);
    chk("rtemp", rh + 11'h001, rt);
    chk("ltemp", 11'h005, {3'b000, lt});
    dop = 1'b1;
    strobe(1, 0, 0);
    pins(1, 1, 8'h04);
    chk("sup", 11'h001, {10'h000, sup});
    pair(rh + 11'h001, 8'h05);
    pins(1, 1, 8'h14);
    strobe(1, 0, 0);
    strobe(0, 1, 0);
    strobe(1, 0, 0);
    chk("sup", 11'h000, {10'h000, sup});
    pair(rh, lh + 8'h01);
    pins(0, 1, 8'h44);
    dop = 1'b0;
    pair(rl - 11'h001, 8'h05);
    pins(0, 1, 8'h48);
    strobe(1, 0, 0);
    strobe(0, 1, 0);
    pins(1, 1, 8'h00);
    $display("test interrupt done");
    mode = 8'h01;
    pair(rl - 11'h001, 8'h05);
    strobe(1, 0, 0);
    pins(0, 1, 8'h08);
    repeat (6) begin
      r = rh - 11'h003 + 11'($urandom % 7);
      pair(r, 8'h05);
      pins(!hi(r, rh), 1, {3'b000, hi(r, rh), 4'h0});
    end
    pair(rc + 11'h001, 8'h05);
    pins(0, 0, 8'h12);
    pair(rc - {hy, 3'b000}, 8'h05);
    pins(0, 0, 8'h12);
    pair(rc - {hy, 3'b000} - 11'h001, 8'h05);
    pins(0, 1, 8'h10);
    pair(rh, 8'h05);
    strobe(0, 1, 1);
    pair(rh, lc + 8'h01);
    pins(1, 0, 8'h41);
    pair(rh, lc - hy - 8'h01);
    pins(1, 1, 8'h40);
    strobe(0, 1, 0);
    en = 5'h00;
    pair(rc + 11'h001, lc + 8'h01);
    chk("outs", 11'h003, {9'h000, al_n, cr_n});
    pair(rh, 8'h05);
    en = 5'h1f;
    run(2);
    pins(1, 1, 8'h00);
    pair(11'h7f8, 8'hfe);
    pins(0, 1, 8'h08);
    chk("ltemp", 11'h0fe, {3'b000, lt});
    pair(rh, 8'h05);
    pins(1, 1, 8'h00);
    $display("test comparator done");
    mode = 8'h00;
    fq = 1'b1;
    pair(rh + 11'h001, 8'h05);
    pair(rh + 11'h001, 8'h05);
    pins(1, 1, 8'h00);
    pair(rh + 11'h001, 8'h05);
    pins(0, 1, 8'h10);
    strobe(1, 0, 0);
    strobe(0, 1, 0);
    pair(rh, lh + 8'h01);
    pins(0, 1, 8'h40);
    $display("test fault queue done");
    slow = 1'b1;
    rv = 11'h001;
    sd = 1'b0;
    while (!go && cyc < 20000) run(1);
    run(3);
    chk("busy", 11'h001, {10'h000, st[7]});
    sd = 1'b1;
    run(4);
    chk("abort", 11'h001, {10'h000, nab != 0});
    chk("rtemp", rh, rt);
    pins(0, 1, 8'h40);
    nst = 0;
    run(60);
    chk("starts", 11'h000, 11'(nst));
    slow = 1'b0;
    rv = 11'h020;
    sd = 1'b0;
    run(60);
    chk("many", 11'h001, {10'h000, nst > 1});
    chk("rtemp", 11'h020, rt);
    sd = 1'b1;
    run(30);
    $display("test shutdown done");
    stop_test();
  end
endmodule : tb
`default_nettype wire

// [tb/tla_core_asserts.sv]
// Port checks for the limit alert core
`timescale 1ns/1ps
`default_nettype none
module tla_core_asserts (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic SHUTDOWN,
  input wire logic [7:0] ALERT_MODE_REG,
  input wire logic STATUS_RD,
  input wire logic SUPPRESS_WR,
  input wire logic SUPPRESS_WDATA,
  input wire logic ADC_DONE,
  input wire logic ADC_START,
  input wire logic ADC_ABORT,
  input wire logic [tla_pkg::STATUS_W-1:0] STATUS,
  input wire logic ALERT_SUPPRESS_BIT,
  input wire logic ALERT_N,
  input wire logic CRIT_N
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!ARST_N);
  property p_fall; $fell(ALERT_N) |-> $past(ADC_DONE); endproperty
  a_fall: assert property (p_fall) else $error("alert fell without a result");
  property p_crit; !$stable(CRIT_N) |-> $past(ADC_DONE); endproperty
  a_crit: assert property (p_crit) else $error("critical moved without a result");
  property p_start; ADC_START |=> !ADC_START; endproperty
  a_start: assert property (p_start) else $error("start pulse too long");
  property p_abort; ADC_ABORT |=> !ADC_ABORT; endproperty
  a_abort: assert property (p_abort) else $error("abort pulse too long");
  property p_busy; ADC_START |=> STATUS[tla_pkg::ST_BUSY]; endproperty
  a_busy: assert property (p_busy) else $error("busy missing");
  // Past read excluded: a read one edge earlier may already have cleared the flags
  property p_rdsup; !ALERT_MODE_REG[0] && !$past(ALERT_MODE_REG[0]) && STATUS_RD
    && !$past(STATUS_RD) && (STATUS & 8'h5b) != 8'h00 |=> ALERT_SUPPRESS_BIT; endproperty
  a_rdsup: assert property (p_rdsup) else $error("read did not set suppress");
  property p_supclr; SUPPRESS_WR && !SUPPRESS_WDATA && !STATUS_RD |=> !ALERT_SUPPRESS_BIT;
  endproperty
  a_supclr: assert property (p_supclr) else $error("suppress not cleared");
  property p_suphold; ALERT_SUPPRESS_BIT && ALERT_N && !SUPPRESS_WR |=> ALERT_N; endproperty
  a_suphold: assert property (p_suphold) else $error("alert despite suppress");
  property p_cmpsup; ALERT_MODE_REG[0] && !ALERT_SUPPRESS_BIT && !SUPPRESS_WR
    |=> !ALERT_SUPPRESS_BIT; endproperty
  a_cmpsup: assert property (p_cmpsup) else $error("suppress set in comparator");
  property p_sdkeep; $rose(SHUTDOWN) && !STATUS_RD |=> $stable(ALERT_N) && $stable(CRIT_N);
  endproperty
  a_sdkeep: assert property (p_sdkeep) else $error("shutdown moved an output");
endmodule : tla_core_asserts
bind tla_alert_core tla_core_asserts i_chk (.CLK(CLK), .ARST_N(ARST_N), .SHUTDOWN(SHUTDOWN),
  .ALERT_MODE_REG(ALERT_MODE_REG), .STATUS_RD(STATUS_RD), .SUPPRESS_WR(SUPPRESS_WR),
  .SUPPRESS_WDATA(SUPPRESS_WDATA), .ADC_DONE(ADC_DONE), .ADC_START(ADC_START),
  .ADC_ABORT(ADC_ABORT), .STATUS(STATUS), .ALERT_SUPPRESS_BIT(ALERT_SUPPRESS_BIT),
  .ALERT_N(ALERT_N), .CRIT_N(CRIT_N));
`default_nettype wire

// [tb/tla_fe_model.sv]
// Converter front end model, prompt or slow
`timescale 1ns/1ps
`default_nettype none
module tla_fe_model (
  input wire logic clk,
  input wire logic start,
  input wire logic remote,
  input wire logic abort,
  input wire logic slow,
  input wire logic [10:0] rem_val,
  input wire logic [7:0] loc_val,
  output logic done,
  output logic [10:0] result
);
  int cnt = 0;
  logic d = 1'b0;
  logic ch = 1'b0;
  logic [10:0] junk = 11'h555;
  always_ff @(posedge clk) begin
    junk <= ~junk;
    d <= 1'b0;
    if (abort) begin
      cnt <= 0;
    end else if (start) begin
      cnt <= slow ? 12 : 3;
      ch <= remote;
    end else if (cnt == 1) begin
      d <= 1'b1;
      cnt <= 0;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end
  end
  assign done = d;
  // Junk outside the done cycle so a stale result cannot pass
  assign result = d ? (ch ? rem_val : {{3{loc_val[7]}}, loc_val}) : junk;
endmodule : tla_fe_model
`default_nettype wire
